// ===== mcd_datapath.sv
// Memory controller datapath: address conversion and queues, write data
// queues, write ECC, read check and correction, frame CRCs, lane crossing.
// Assumes control blocks drive selects and starts on sys_clk, and the
// sync pulses come from clock control on sys_clk.
//
`include "mcd_regs.svh"
`default_nettype none
module mcd_datapath (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cache_to_mem_sync_pulse,
  input wire logic mem_to_cache_sync_pulse,
  input wire logic single_chan_mode,
  input wire logic failover_mode,
  input wire logic [39:0] mem_top_addr,
  input wire logic [39:0] req_phys_addr,
  input wire logic req_push_rd,
  input wire logic req_push_wr,
  input wire logic [2:0] rdq_sel,
  input wire logic [2:0] wrq_sel,
  output logic [35:0] rdq_entry,
  output logic [35:0] wrq_entry,
  input wire logic [1:0] wdq_we,
  input wire logic [2:0] wdq_line,
  input wire logic [2:0] wdq_beat,
  input wire logic [63:0] wdq_wdata,
  input wire logic [1:0] wr_src,
  input wire logic [2:0] wr_line,
  input wire logic wr_start,
  output logic [143:0] mem_wr_data,
  output logic mem_wr_valid,
  input wire logic rd_valid,
  input wire logic rd_scrub,
  input wire logic [143:0] rd_data,
  output logic [127:0] cache_data,
  output logic [27:0] cache_check,
  output logic cache_valid,
  output logic read_single_err_out,
  output logic read_multi_err_out,
  output logic scrub_single_err_out,
  output logic scrub_multi_err_out,
  output logic [3:0] err_status,
  input wire logic [3:0] err_clear,
  input wire logic [25:0] sb_cmd_a,
  input wire logic [71:0] sb_bc_data,
  output logic [13:0] sb_crc_a,
  output logic [21:0] sb_crc_bc,
  input wire logic nb_valid,
  input wire logic [71:0] nb_data,
  input wire logic [11:0] nb_crc,
  output logic crc_err_dram,
  output logic crc_err_chan,
  input wire logic lane_clk_pin,
  input wire logic lane_sync_pin,
  input wire logic [11:0] lane_data_pin,
  output logic [11:0] lane_rd_data,
  output logic lane_rd_valid,
  output logic lane_drift_err
);
  ////////////////////////////////////////////////////////////////////////
  // Arithmetic shared across the paths

  // Xor of one-based positions of set bits; the core of the ECC and Hamming check codes
  function automatic logic [7:0] mcd_pos_xor(input logic [127:0] d,
    input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++)
      if (d[i])
        s = s ^ 8'(i + 1);
    return s;
  endfunction

  // Upper seven bits spare; parity in bit 8 separates single from multi
  function automatic logic [15:0] mcd_ecc16(input logic [127:0] d);
    return {7'h00, ^d, mcd_pos_xor(d, 128)};
  endfunction

  function automatic logic [6:0] mcd_ham7(input logic [31:0] w);
    logic [7:0] p;
    p = mcd_pos_xor({96'h0, w}, 32);
    return {^w, p[5:0]};
  endfunction

  // Serial CRC, msb first, width w, result masked to w bits
  function automatic logic [21:0] mcd_crc(input logic [71:0] d,
    input int n, input int w, input logic [21:0] poly);
    logic [21:0] c, m;
    logic fb;
    c = 22'h000000;
    m = 22'((23'h000001 << w) - 23'h000001);
    for (int i = n - 1; i >= 0; i--) begin
      fb = d[i] ^ c[w - 1];
      c = ((c << 1) ^ (fb ? poly : 22'h000000)) & m;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address conversion and queues

  logic [35:0] rdq_mem_r [0:7];
  logic [35:0] wrq_mem_r [0:7];
  logic [2:0] rdq_tail_r, wrq_tail_r;
  logic [35:0] rdq_entry_r, wrq_entry_r;

  // Field slicing, range error and even parity over the whole word
  wire aerr = req_phys_addr >= mem_top_addr;
  wire [33:0] conv_body = {
    req_phys_addr[`MCD_PA_RANK_LSB +: 2],
    req_phys_addr[`MCD_PA_BANK_LSB +: 3],
    req_phys_addr[`MCD_PA_COL_LSB +: 14],
    req_phys_addr[`MCD_PA_ROW_LSB +: 15]};
  wire [35:0] conv_addr = {^{aerr, conv_body}, aerr, conv_body};
  // Queue pushes cross only on the cache-to-memory pulse
  wire push_rd = req_push_rd & cache_to_mem_sync_pulse;
  wire push_wr = req_push_wr & cache_to_mem_sync_pulse;

  // Tails wrap; control never pushes past eight in flight
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdq_tail_r <= 3'h0;
      wrq_tail_r <= 3'h0;
      rdq_entry_r <= 36'h0;
      wrq_entry_r <= 36'h0;
    end else begin
      if (push_rd) begin
        rdq_mem_r[rdq_tail_r] <= conv_addr;
        rdq_tail_r <= rdq_tail_r + 3'h1;
      end
      if (push_wr) begin
        wrq_mem_r[wrq_tail_r] <= conv_addr;
        wrq_tail_r <= wrq_tail_r + 3'h1;
      end
      rdq_entry_r <= rdq_mem_r[rdq_sel];
      wrq_entry_r <= wrq_mem_r[wrq_sel];
    end
  end
  assign rdq_entry = rdq_entry_r;
  assign wrq_entry = wrq_entry_r;

  ////////////////////////////////////////////////////////////////////////
  // Write data queues: [bank][file][entry]; two spare bits read as zero

  logic [65:0] wdq_r [0:1][0:1][0:31];
  wire [4:0] wdq_waddr = {wdq_line, wdq_beat[2:1]};

  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < 2; b++)
      if (wdq_we[b])
        wdq_r[b][wdq_beat[0]][wdq_waddr] <= {2'b00, wdq_wdata};
  end

  ////////////////////////////////////////////////////////////////////////
  // Outgoing write path

  mcd_pkg::mcd_tx_e tx_state_r;
  logic [2:0] tx_beat_r, tx_line_r;
  logic [1:0] tx_src_r;
  logic tx_single_r;
  logic [127:0] scrub_word_r;
  logic [143:0] mem_wr_data_r;
  logic mem_wr_valid_r;

  wire [2:0] tx_last = tx_single_r ? 3'h7 : 3'h3;
  wire [1:0] tx_widx = tx_single_r ? tx_beat_r[2:1] : tx_beat_r[1:0];
  wire [4:0] wdq_raddr = {tx_line_r, tx_widx};
  wire tx_bank = (tx_src_r == mcd_pkg::MCD_SRC_BANK1);
  wire [127:0] wdq_word = {wdq_r[tx_bank][1][wdq_raddr][63:0],
    wdq_r[tx_bank][0][wdq_raddr][63:0]};
  wire [127:0] tx_word = (tx_src_r == mcd_pkg::MCD_SRC_SCRUB) ?
    scrub_word_r : wdq_word;
  wire [15:0] tx_ecc = mcd_ecc16(tx_word);
  wire [143:0] tx_full = {tx_ecc, tx_word};
  // Half bus: low packet is ecc[7:0] with data[63:0], then upper half
  wire [71:0] tx_half = tx_beat_r[0] ? {tx_ecc[15:8], tx_word[127:64]} :
    {tx_ecc[7:0], tx_word[63:0]};
  wire [143:0] tx_beat_data = tx_single_r ? {72'h0, tx_half} : tx_full;

  // Starts are ignored while a line is still going out
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_state_r <= mcd_pkg::MCD_TX_IDLE;
      tx_beat_r <= 3'h0;
      tx_line_r <= 3'h0;
      tx_src_r <= 2'h0;
      tx_single_r <= 1'b0;
    end else begin
      case (tx_state_r)
        mcd_pkg::MCD_TX_IDLE: begin
          if (wr_start) begin
            tx_state_r <= mcd_pkg::MCD_TX_SEND;
            tx_beat_r <= 3'h0;
            tx_line_r <= wr_line;
            tx_src_r <= wr_src;
            tx_single_r <= single_chan_mode;
          end
        end
        mcd_pkg::MCD_TX_SEND: begin
          tx_beat_r <= tx_beat_r + 3'h1;
          if (tx_beat_r == tx_last)
            tx_state_r <= mcd_pkg::MCD_TX_IDLE;
        end
        default: tx_state_r <= mcd_pkg::MCD_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_wr_valid_r <= 1'b0;
      mem_wr_data_r <= 144'h0;
    end else begin
      mem_wr_valid_r <= (tx_state_r == mcd_pkg::MCD_TX_SEND);
      mem_wr_data_r <= tx_beat_data;
    end
  end
  assign mem_wr_valid = mem_wr_valid_r;
  assign mem_wr_data = mem_wr_data_r;

  ////////////////////////////////////////////////////////////////////////
  // Read return path

  logic [71:0] half_r;
  logic half_have_r;
  logic [143:0] raw_r;
  logic raw_v_r, raw_scrub_r;
  logic [127:0] hold_r, cache_data_r;
  logic hold_v_r, cache_valid_r;
  logic [27:0] cache_check_r;
  logic [3:0] err_pulse_r, err_status_r;

  // Second packet completes the word: upper ecc and data come last
  wire merge_done = rd_valid & single_chan_mode & half_have_r;
  wire [143:0] merged = {rd_data[71:64], half_r[71:64],
    rd_data[63:0], half_r[63:0]};
  wire raw_load = rd_valid & (~single_chan_mode | half_have_r);

  // Check stage on the registered word
  wire [127:0] chk_d = raw_r[127:0];
  wire [15:0] chk_e = raw_r[143:128];
  wire [7:0] syn = mcd_pos_xor(chk_d, 128) ^ chk_e[7:0];
  wire par_bad = (^chk_d) ^ chk_e[8];
  wire syn_ok = (syn >= 8'h01) && (syn <= 8'h80);
  wire chk_single = raw_v_r & par_bad & (syn == 8'h00 | syn_ok);
  wire chk_multi = raw_v_r & ~chk_single &
    ((syn != 8'h00) | par_bad | (chk_e[15:9] != 7'h00));
  wire [127:0] flip = 128'h1 << (syn - 8'h01);
  // Only a located single error is flipped; multi leaves data alone
  wire [127:0] chk_fixed = (par_bad & syn_ok) ? chk_d ^ flip : chk_d;
  wire [3:0] err_now = {chk_multi & raw_scrub_r, chk_single & raw_scrub_r,
    chk_multi & ~raw_scrub_r, chk_single & ~raw_scrub_r};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      half_have_r <= 1'b0;
      half_r <= 72'h0;
      raw_v_r <= 1'b0;
      raw_scrub_r <= 1'b0;
      raw_r <= 144'h0;
    end else begin
      if (rd_valid && single_chan_mode && !half_have_r)
        half_r <= rd_data[71:0];
      if (rd_valid && single_chan_mode)
        half_have_r <= ~half_have_r;
      raw_v_r <= raw_load;
      if (raw_load) begin
        raw_r <= merge_done ? merged : rd_data;
        raw_scrub_r <= rd_scrub;
      end
    end
  end

  // Corrected data waits for the memory-to-cache pulse; scrub diverts
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_v_r <= 1'b0;
      hold_r <= 128'h0;
      scrub_word_r <= 128'h0;
      cache_valid_r <= 1'b0;
      cache_data_r <= 128'h0;
      cache_check_r <= 28'h0;
    end else begin
      if (raw_v_r && raw_scrub_r)
        scrub_word_r <= chk_fixed;
      if (raw_v_r && !raw_scrub_r) begin
        hold_r <= chk_fixed;
        hold_v_r <= 1'b1;
      end else if (mem_to_cache_sync_pulse)
        hold_v_r <= 1'b0;
      cache_valid_r <= hold_v_r & mem_to_cache_sync_pulse;
      if (hold_v_r && mem_to_cache_sync_pulse) begin
        cache_data_r <= hold_r;
        for (int w = 0; w < 4; w++)
          cache_check_r[w * 7 +: 7] <= mcd_ham7(hold_r[w * 32 +: 32]);
      end
    end
  end
  assign cache_data = cache_data_r;
  assign cache_check = cache_check_r;
  assign cache_valid = cache_valid_r;

  // Error pulses and sticky status; a new error beats its own clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      err_pulse_r <= 4'h0;
      err_status_r <= 4'h0;
    end else begin
      err_pulse_r <= err_now;
      err_status_r <= (err_status_r & ~err_clear) | err_now;
    end
  end
  assign read_single_err_out = err_pulse_r[0];
  assign read_multi_err_out = err_pulse_r[1];
  assign scrub_single_err_out = err_pulse_r[2];
  assign scrub_multi_err_out = err_pulse_r[3];
  assign err_status = err_status_r;

  ////////////////////////////////////////////////////////////////////////
  // Frame CRCs

  wire [21:0] crc_a_n = mcd_crc({46'h0, sb_cmd_a}, 26, 14, `MCD_POLY_A14);
  wire [21:0] crc_a_f = mcd_crc({46'h0, sb_cmd_a}, 26, 10, `MCD_POLY_F10);
  wire [21:0] crc_b_n = mcd_crc(sb_bc_data, 72, 22, `MCD_POLY_B22);
  wire [21:0] crc_b_f = mcd_crc(sb_bc_data, 72, 10, `MCD_POLY_F10);
  wire [21:0] crc_n_n = mcd_crc(nb_data, 72, 12, `MCD_POLY_N12);
  wire [21:0] crc_n_f = mcd_crc(nb_data, 72, 6, `MCD_POLY_N6);
  // Failover compares only the low six received bits
  wire nb_bad = failover_mode ? (crc_n_f[5:0] != nb_crc[5:0]) :
    (crc_n_n[11:0] != nb_crc);
  logic [13:0] sb_crc_a_r;
  logic [21:0] sb_crc_bc_r;
  logic crc_err_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sb_crc_a_r <= 14'h0;
      sb_crc_bc_r <= 22'h0;
      crc_err_r <= 1'b0;
    end else begin
      sb_crc_a_r <= failover_mode ? crc_a_f[13:0] : crc_a_n[13:0];
      sb_crc_bc_r <= failover_mode ? crc_b_f : crc_b_n;
      crc_err_r <= nb_valid & nb_bad;
    end
  end
  assign sb_crc_a = sb_crc_a_r;
  assign sb_crc_bc = sb_crc_bc_r;
  assign crc_err_dram = crc_err_r;
  assign crc_err_chan = crc_err_r;

  ////////////////////////////////////////////////////////////////////////
  // Lane crossing with a memory-rate tick

  logic [3:0] div_r;
  mcd_lane_if lane ();

  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      div_r <= 4'h0;
    else if (div_r == 4'(`MCD_MEM_DIV - 1))
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end
  assign lane.mem_tick = (div_r == 4'h0);

  mcd_lane_fifo u_lane (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .lane_clk_pin(lane_clk_pin),
    .lane_sync_pin(lane_sync_pin),
    .lane_data_pin(lane_data_pin),
    .lf(lane.fifo)
  );
  assign lane_rd_data = lane.rd_data;
  assign lane_rd_valid = lane.rd_valid;
  assign lane_drift_err = lane.drift_err;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence four_beats; mem_wr_valid[*4] ##1 !mem_wr_valid; endsequence
  sequence eight_beats; mem_wr_valid[*8] ##1 !mem_wr_valid; endsequence
  addr_parity_a: assert property (^conv_addr == 1'b0)
    else $error("converted address parity not even");
  queue_store_a: assert property (push_rd |=>
    rdq_mem_r[$past(rdq_tail_r)] == $past(conv_addr))
    else $error("read address queue missed a push");
  normal_send_a: assert property (wr_start && !single_chan_mode &&
    tx_state_r == mcd_pkg::MCD_TX_IDLE |-> ##2 four_beats)
    else $error("normal write not four beats");
  single_send_a: assert property (wr_start && single_chan_mode &&
    tx_state_r == mcd_pkg::MCD_TX_IDLE |-> ##2 eight_beats)
    else $error("single channel write not eight beats");
  status_set_a: assert property (read_single_err_out |-> err_status[0])
    else $error("single error not recorded in status");
  cache_sync_a: assert property (cache_valid |->
    $past(mem_to_cache_sync_pulse) && $past(hold_v_r))
    else $error("cache data without sync pulse");
  hamming_out_a: assert property (cache_valid |->
    cache_check[6:0] == mcd_ham7(cache_data[31:0]) &&
    cache_check[27:21] == mcd_ham7(cache_data[127:96]))
    else $error("cache check bits wrong");
  crc_flag_a: assert property (nb_valid && nb_bad |=>
    crc_err_dram && crc_err_chan)
    else $error("northbound crc mismatch not flagged");
endmodule
`default_nettype wire

// ===== mcd_regs.svh
// Constants of the memory controller datapath: field positions and timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MCD_REGS_SVH
`define MCD_REGS_SVH
// Converted DIMM address layout
`define MCD_ROW_LSB 0
`define MCD_COL_LSB 15
`define MCD_BANK_LSB 29
`define MCD_RANK_LSB 32
`define MCD_AERR_BIT 34
`define MCD_APAR_BIT 35
// Physical address slices feeding the converter
`define MCD_PA_COL_LSB 6
`define MCD_PA_BANK_LSB 20
`define MCD_PA_RANK_LSB 23
`define MCD_PA_ROW_LSB 25
// Clock rates and the derived memory-rate divider
`define MCD_SYS_PERIOD_NS 50
`define MCD_MEM_PERIOD_NS 400
`define MCD_MEM_DIV \
  ((`MCD_MEM_PERIOD_NS + `MCD_SYS_PERIOD_NS - 1) / `MCD_SYS_PERIOD_NS)
// Lane crossing
`define MCD_SYNC_COUNT 16
`define MCD_WP_START 2'h2
// Frame check polynomials (plain defaults)
`define MCD_POLY_A14 22'h0006B3
`define MCD_POLY_F10 22'h00030F
`define MCD_POLY_B22 22'h01C8C3
`define MCD_POLY_N12 22'h00080F
`define MCD_POLY_N6 22'h000021
`endif

// ===== mcd_pkg.sv
// Types shared by the memory controller datapath files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mcd_pkg;
  typedef enum logic [1:0] {MCD_SRC_BANK0, MCD_SRC_BANK1,
    MCD_SRC_SCRUB} mcd_src_e;
  typedef enum logic {MCD_TX_IDLE, MCD_TX_SEND} mcd_tx_e;
  typedef logic [35:0] mcd_dimm_addr_t;
endpackage
`default_nettype wire

// ===== mcd_lane_if.sv
// Bundle between the datapath top and its lane crossing FIFO.
// Assumes both ends run on sys_clk.
`default_nettype none
interface mcd_lane_if;
  logic mem_tick;
  logic [11:0] rd_data;
  logic rd_valid;
  logic drift_err;
  modport top (output mem_tick, input rd_data, input rd_valid,
    input drift_err);
  modport fifo (input mem_tick, output rd_data, output rd_valid,
    output drift_err);
endinterface
`default_nettype wire

// ===== mcd_lane_fifo.sv
// Northbound lane crossing FIFO, 12 bits by four entries in flip-flops.
// Assumes the lane clock pin is slow against sys_clk and gets sampled.
`include "mcd_regs.svh"
`default_nettype none
module mcd_lane_fifo (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic lane_clk_pin,
  input wire logic lane_sync_pin,
  input wire logic [11:0] lane_data_pin,
  mcd_lane_if.fifo lf
);
  logic [2:0] clk_s_r;
  logic [1:0] sync_s_r;
  logic [11:0] data_a_r, data_b_r;
  logic [4:0] sync_cnt_r;
  logic wr_en_r, rd_en_a_r, rd_en_r;
  logic [1:0] wp_r, rp_r;
  logic [11:0] mem_r [0:3];
  logic [11:0] rd_data_r;
  logic rd_valid_r, drift_r;

  // Lane edge seen on the second and third sampled stage only
  wire lane_edge = clk_s_r[1] & ~clk_s_r[2];
  wire do_wr = lane_edge & wr_en_r;
  wire do_rd = lf.mem_tick & rd_en_r;
  wire overrun = do_wr & (wp_r + 2'h1 == rp_r) & ~do_rd;
  wire underrun = do_rd & (wp_r == rp_r) & ~do_wr;

  // Two-flop sampling of the sync and data pins, three flops on the lane clock
  always_ff @(posedge sys_clk) begin
    clk_s_r <= {clk_s_r[1:0], lane_clk_pin};
    sync_s_r <= {sync_s_r[0], lane_sync_pin};
    data_a_r <= lane_data_pin;
    data_b_r <= data_a_r;
  end

  // Write side opens after enough sync indications
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_cnt_r <= 5'h00;
      wr_en_r <= 1'b0;
    end else if (lane_edge && sync_s_r[1] && !wr_en_r) begin
      sync_cnt_r <= sync_cnt_r + 5'h01;
      wr_en_r <= (sync_cnt_r == 5'(`MCD_SYNC_COUNT - 1));
    end
  end

  // Read enable is the write enable after a synchroniser
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_en_a_r <= 1'b0;
      rd_en_r <= 1'b0;
    end else begin
      rd_en_a_r <= wr_en_r;
      rd_en_r <= rd_en_a_r;
    end
  end

  // Start two slots ahead so each word rests before it is read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r <= `MCD_WP_START;
      rp_r <= 2'h0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 12'h000;
      drift_r <= 1'b0;
    end else begin
      if (do_wr) begin
        mem_r[wp_r] <= data_b_r;
        wp_r <= wp_r + 2'h1;
      end
      if (do_rd) begin
        rd_data_r <= mem_r[rp_r];
        rp_r <= rp_r + 2'h1;
      end
      rd_valid_r <= do_rd;
      // Sticky until reset, which is how a retrain restarts the crossing
      if (overrun || underrun)
        drift_r <= 1'b1;
    end
  end

  assign lf.rd_data = rd_data_r;
  assign lf.rd_valid = rd_valid_r;
  assign lf.drift_err = drift_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rd_follow_a: assert property ($rose(wr_en_r) |-> ##2 $rose(rd_en_r))
    else $error("read pointer enable not two cycles after write");
  drift_hold_a: assert property (drift_r |=> drift_r)
    else $error("drift error dropped without reset");
endmodule
`default_nettype wire

// ===== mcd_lane_model.sv
// Far-side lane model: recovered clock, sync and counting data.
// Assumes run rises once the block is out of reset.
`default_nettype none
module mcd_lane_model (
  input wire logic run,
  output logic lane_clk,
  output logic lane_sync,
  output logic [11:0] lane_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free-running clock, phase offset against sys_clk
  initial begin
    lane_clk = 1'b0;
    lane_sync = 1'b0;
    lane_data = 12'h000;
    wait (run);
    #137;
    forever begin
      #200 lane_clk = 1'b1;
      #200 lane_clk = 1'b0;
      lane_sync = 1'b1;
      lane_data = lane_data + 12'h001; // Moves far from the sampled edge
    end
  end
endmodule
`default_nettype wire

// ===== mcd_tb.sv
// Self-checking bench for the datapath top, task driven.
// Assumes mcd_regs.svh and the lane model are compiled alongside.
`include "mcd_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, cache_to_mem_sync_pulse, mem_to_cache_sync_pulse;
  logic single_chan_mode, failover_mode, req_push_rd, req_push_wr, wr_start;
  logic rd_valid, rd_scrub, nb_valid, cache_valid, mem_wr_valid, lane_run;
  logic read_single_err_out, read_multi_err_out, crc_err_dram, crc_err_chan;
  logic scrub_single_err_out, scrub_multi_err_out, lane_rd_valid;
  logic lane_drift_err, lane_clk_pin, lane_sync_pin;
  logic [1:0] wdq_we, wr_src;
  logic [2:0] rdq_sel, wrq_sel, wdq_line, wdq_beat, wr_line;
  logic [3:0] err_status, err_clear;
  logic [6:0] ep;
  logic [6:0] xe [6];
  logic [11:0] nb_crc, lane_data_pin, lane_rd_data, v0, v1;
  logic [13:0] sb_crc_a;
  logic [21:0] sb_crc_bc;
  logic [25:0] sb_cmd_a;
  logic [27:0] cache_check;
  logic [35:0] rdq_entry, wrq_entry;
  logic [39:0] mem_top_addr, req_phys_addr;
  logic [63:0] wdq_wdata;
  logic [71:0] sb_bc_data, nb_data;
  logic [127:0] cache_data, scw;
  logic [127:0] fl [6];
  logic [143:0] mem_wr_data, rd_data;
  int errors, checks;
  localparam logic [39:0] a0 = 40'h12_3456_789A;
  localparam logic [39:0] top = 40'h80_0000_0000;
  localparam logic [127:0] dat = 128'h0123456789ABCDEFFEDCBA9876543210;
  localparam logic [127:0] f1 = 128'h20;
  localparam logic [127:0] f2 = f1 | (f1 << 72);
  localparam logic [71:0] bcd = 72'hA1_B2C3_D4E5_F607_1829;
  localparam logic [71:0] nbd = 72'h5A_0F1E_2D3C_4B69_7887;
  localparam logic [71:0] cma = 72'h2A5_C3E1;

  mcd_datapath DUT (.*);
  mcd_lane_model lane (.run(lane_run), .lane_clk(lane_clk_pin),
    .lane_sync(lane_sync_pin), .lane_data(lane_data_pin));

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Pulses are one cycle wide, so collect them between clears
  always @(negedge sys_clk)
    ep <= ep | {crc_err_chan, crc_err_dram, cache_valid, scrub_multi_err_out,
      scrub_single_err_out, read_multi_err_out, read_single_err_out};
////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ecc16(input logic [127:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 128; i++)
      s = d[i] ? s ^ 8'(i + 1) : s;
    return {7'h00, ^d, s};
  endfunction
  function automatic logic [6:0] ham7(input logic [31:0] w);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 32; i++)
      s = w[i] ? s ^ 6'(i + 1) : s;
    return {^w, s};
  endfunction
  function automatic logic [21:0] crc(input logic [71:0] d, input int n,
    input int w, input logic [21:0] p);
    logic [21:0] c;
    c = 22'h0;
    for (int i = n - 1; i >= 0; i--)
      c = ((c << 1) & ((22'h1 << w) - 22'h1)) ^
        (d[i] ^ c[w - 1] ? p : 22'h0);
    return c;
  endfunction
  function automatic logic [34:0] conv(input logic [39:0] a);
    return {a >= top, a[24:23], a[22:20], a[19:6], a[39:25]};
  endfunction
  // Bank beats carry their own index in every nibble
  function automatic logic [127:0] wd(input int k);
    int b;
    b = 2 * k + 8 * wr_src[0];
    return wr_src[1] ? scw : {{16{4'(b + 1)}}, {16{4'(b)}}};
  endfunction
  task automatic cmp(input logic [143:0] got, input logic [143:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [39:0] a, input logic wr, input logic sy);
    req_phys_addr <= a;
    req_push_rd <= ~wr;
    req_push_wr <= wr;
    cache_to_mem_sync_pulse <= sy;
    @(posedge sys_clk);
    {req_push_rd, req_push_wr, cache_to_mem_sync_pulse} <= 3'h0;
    @(posedge sys_clk);
  endtask
  task automatic sendchk(input logic sm);
    logic [143:0] e;
    int n;
    n = 0;
    while (mem_wr_valid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    for (int j = 0; j < (sm ? 8 : 4); j++) begin
      e = {ecc16(wd(sm ? j / 2 : j)), wd(sm ? j / 2 : j)};
      if (sm)
        e = j % 2 ? {72'h0, e[143:136], e[127:64]} :
          {72'h0, e[135:128], e[63:0]};
      cmp(mem_wr_valid, 1'b1);
      cmp(sm ? 144'(mem_wr_data[71:0]) : mem_wr_data, e);
      @(negedge sys_clk);
    end
    cmp(mem_wr_valid, 1'b0);
  endtask
  // A second start lands mid-send and must be ignored
  task automatic send(input logic [1:0] s, input logic sm);
    wr_src <= s;
    single_chan_mode <= sm;
    wr_line <= 3'h7;
    wr_start <= 1'b1;
    @(posedge sys_clk);
    wr_start <= 1'b0;
    fork
      sendchk(sm);
      begin
        repeat (3) @(posedge sys_clk);
        wr_start <= 1'b1;
        @(posedge sys_clk);
        wr_start <= 1'b0;
      end
    join
    @(posedge sys_clk);
  endtask
  task automatic rdgo(input logic [143:0] d, input logic sc, input logic sm);
    ep = 7'h00;
    single_chan_mode <= sm;
    rd_scrub <= sc;
    rd_valid <= 1'b1;
    rd_data <= sm ? {72'h0, d[135:128], d[63:0]} : d;
    @(posedge sys_clk);
    if (sm) begin
      rd_data <= {72'h0, d[143:136], d[127:64]};
      @(posedge sys_clk);
    end
    rd_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    mem_to_cache_sync_pulse <= 1'b1;
    @(posedge sys_clk);
    mem_to_cache_sync_pulse <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic lane_next(output logic [11:0] v);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (lane_rd_valid !== 1'b1 && n < 400);
    cmp(lane_rd_valid, 1'b1);
    v = lane_rd_data;
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////
  // Watchdog, over thirty times the expected run
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {cache_to_mem_sync_pulse, mem_to_cache_sync_pulse, single_chan_mode,
      failover_mode, req_push_rd, req_push_wr, wr_start, rd_valid,
      rd_scrub, nb_valid, lane_run} = '0;
    {req_phys_addr, rdq_sel, wrq_sel, wdq_we, wdq_line, wdq_beat, wdq_wdata,
      wr_src, wr_line, rd_data, err_clear, sb_cmd_a, sb_bc_data, nb_data,
      nb_crc} = '0;
    mem_top_addr = top;
    scw = dat;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    lane_run <= 1'b1;
    @(posedge sys_clk);
    push(a0, 1'b0, 1'b1);
    push(40'h0, 1'b0, 1'b0);
    push(a0 ^ 40'h40, 1'b0, 1'b1);
    push(a0 | top, 1'b1, 1'b1);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp(rdq_entry, {^conv(a0), conv(a0)});
    cmp(wrq_entry, {^conv(a0 | top), conv(a0 | top)});
    @(posedge sys_clk);
    rdq_sel <= 3'h1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp(rdq_entry, {^conv(a0 ^ 40'h40), conv(a0 ^ 40'h40)});
    @(posedge sys_clk);
    for (int b = 0; b < 16; b++) begin
      wdq_we <= 2'(1 << (b / 8));
      wdq_line <= 3'h7;
      wdq_beat <= 3'(b);
      wdq_wdata <= {16{4'(b)}};
      @(posedge sys_clk);
    end
    wdq_we <= 2'h0;
    send(2'h0, 1'b0);
    send(2'h1, 1'b1);
    fl = '{128'h0, f1, f2, 128'h0, f1, f2};
    xe = '{7'h10, 7'h11, 7'h12, 7'h10, 7'h04, 7'h08};
    for (int i = 0; i < 6; i++) begin
      rdgo({ecc16(dat), dat ^ fl[i]}, i > 3, i == 3);
      cmp(ep, xe[i]);
      cmp(cache_data, i == 2 ? dat ^ f2 : dat);
      if (i == 4)
        send(2'h2, 1'b0);
    end
    for (int w = 0; w < 4; w++)
      cmp(cache_check[w * 7 +: 7], ham7(dat[w * 32 +: 32]));
    cmp(err_status, 4'hF);
    err_clear <= 4'h5;
    @(posedge sys_clk);
    err_clear <= 4'h0;
    @(negedge sys_clk);
    cmp(err_status, 4'hA);
    @(posedge sys_clk);
    // Good then corrupted frame check, normal then failover
    sb_cmd_a <= cma[25:0];
    sb_bc_data <= bcd;
    nb_data <= nbd;
    for (int i = 0; i < 4; i++) begin
      ep = 7'h00;
      failover_mode <= i[1];
      nb_crc <= 12'(crc(nbd, 72, i[1] ? 6 : 12,
        i[1] ? `MCD_POLY_N6 : `MCD_POLY_N12)) ^ 12'(i[0]);
      nb_valid <= 1'b1;
      @(posedge sys_clk);
      nb_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(ep[6:5], {2{i[0]}});
      cmp(sb_crc_a, 14'(crc(cma, 26, i[1] ? 10 : 14,
        i[1] ? `MCD_POLY_F10 : `MCD_POLY_A14)));
      cmp(sb_crc_bc, crc(bcd, 72, i[1] ? 10 : 22,
        i[1] ? `MCD_POLY_F10 : `MCD_POLY_B22));
      @(posedge sys_clk);
    end
    repeat (3) lane_next(v0);
    lane_next(v1);
    cmp(12'(v1 - v0), 12'h001);
    cmp(lane_drift_err, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
